// File: include/pdc_map.svh
// Register offsets, field positions, reset values and fixed codes of the device control bank.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PDC_MAP_SVH
`define PDC_MAP_SVH

`define PDC_ADDR_W 12
`define PDC_OFF_DEVCAP 12'h044
`define PDC_OFF_DEVCTL 12'h048

// device_capabilities fields
`define PDC_CAP_PAYLOAD_LSB 0
`define PDC_CAP_PAYLOAD_MSB 2
`define PDC_CAP_PAYLOAD_RST 3'h4
`define PDC_CAP_SCALE_LSB 26
`define PDC_CAP_SCALE_MSB 27

// device_control fields
`define PDC_CTL_CORR_BIT 0
`define PDC_CTL_NONFATAL_BIT 1
`define PDC_CTL_FATAL_BIT 2
`define PDC_CTL_UNSUP_BIT 3
`define PDC_CTL_RELAX_BIT 4
`define PDC_CTL_PAYLOAD_LSB 5
`define PDC_CTL_PAYLOAD_MSB 7
`define PDC_CTL_EXTTAG_BIT 8
`define PDC_CTL_PHANTOM_BIT 9
`define PDC_CTL_AUXPM_BIT 10
`define PDC_CTL_NOSNOOP_BIT 11
`define PDC_CTL_RDREQ_LSB 12
`define PDC_CTL_RDREQ_MSB 14
`define PDC_CTL_WMASK 16'h01ef

// Payload sizes in bytes
`define PDC_PAYLOAD_128 13'h0080
`define PDC_PAYLOAD_256 13'h0100
`define PDC_PAYLOAD_512 13'h0200
`define PDC_PAYLOAD_1024 13'h0400
`define PDC_PAYLOAD_2048 13'h0800
`define PDC_PAYLOAD_4096 13'h1000
`define PDC_ORIG_REQ_MAX 13'h0080

// Tag limits for sequential tag debug
`define PDC_TAG_MAX_SHORT 8'h1f
`define PDC_TAG_MAX_LONG 8'hff

`endif

// File: include/pdc_pkg.sv
// Types shared by the device control bank and its testbench.
// Assumes pdc_map.svh on the include path.
`include "pdc_map.svh"

package pdc_pkg;

  typedef enum logic [1:0] {
    PDC_SCALE_1P0,
    PDC_SCALE_0P1,
    PDC_SCALE_0P01,
    PDC_SCALE_0P001
  } pdc_scale_t;

  typedef struct packed {
    logic corr_err_report_en;
    logic nonfatal_err_report_en;
    logic fatal_err_report_en;
    logic unsup_req_report_en;
    logic [2:0] payload_size_sel;
    logic ext_tag_en;
  } pdc_ctl_t;

  typedef struct packed {
    logic corr;
    logic nonfatal;
    logic fatal;
    logic unsup;
  } pdc_err_t;

  typedef struct packed {
    logic valid;
    logic [7:0] value;
    logic [1:0] scale;
  } pdc_power_msg_t;

endpackage : pdc_pkg

// File: rtl/pdc_tag_gen.sv
// Sequential tag generator used in debug mode.
// Assumes one clock domain; advance is a one-cycle pulse from the requester logic.
`timescale 1ns/1ps
`include "pdc_map.svh"

module pdc_tag_gen #(
  parameter int TAG_W = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic wide,
  input wire logic advance,
  // Tag out
  output logic [TAG_W-1:0] tag
);

  if (TAG_W != 8) begin : g_bad_tag_w
    $error("pdc_tag_gen supports only 8-bit tags");
  end

  logic [7:0] tag_max;

  assign tag_max = wide ? `PDC_TAG_MAX_LONG : `PDC_TAG_MAX_SHORT;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tag <= 8'h00;
    end else if (!enable) begin
      tag <= 8'h00;
    end else if (tag > tag_max) begin
      // A tag left above the short range by a mode change restarts at zero
      tag <= 8'h00;
    end else if (advance) begin
      if (tag >= tag_max) begin
        tag <= 8'h00;
      end else begin
        tag <= tag + 8'h01;
      end
    end
  end

  property p_tag_range;
    @(posedge clock) disable iff (!resetn)
      (enable && !wide) |=> (tag <= `PDC_TAG_MAX_SHORT);
  endproperty
  a_tag_range: assert property (p_tag_range) else $error("tag above 31 in short mode");

endmodule : pdc_tag_gen

// File: rtl/pdc_regs.sv
// Device control and capabilities register bank of one switch port.
// Assumes a single 20 MHz clock; the power limit message arrives from logic on the same clock.
//
// Operation
// - Upstream port captures power scale from message; downstream reads zero.
// - Scale codes 0..3 mean 1.0x, 0.1x, 0.01x, 0.001x.
// - Bit 0 read-write, reset zero, gates correctable error reporting.
// - Bit 1 read-write, reset zero, gates non-fatal error reporting.
// - Bit 2 read-write, reset zero, gates fatal error reporting.
// - Bit 3 read-write, reset zero, gates unsupported request reporting.
// - Relaxed ordering bit 4 reads zero always.
// - Payload code 0..5 selects 128 to 4096 bytes.
// - Payload codes 6 and 7 act as 128 bytes.
// - Extended tag bit selects tag range 0-31 or 0-255 in debug.
// - Phantom function bit 9 reads zero.
// - Aux power bit 10 reads zero.
// - No-snoop bit 11 reads zero; own requests never set no-snoop.
// - Read request size bits read zero; own requests stay within 128 bytes.
// - Supported payload field resets to code 4, 2048 bytes.
`timescale 1ns/1ps
`include "pdc_map.svh"

module pdc_regs #(
  parameter bit UPSTREAM = 1'b1,
  parameter int ADDR_W = `PDC_ADDR_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Slot power limit message
  input wire pdc_pkg::pdc_power_msg_t power_msg,
  // Error events from the port
  input wire pdc_pkg::pdc_err_t err_detect,
  // Debug control
  input wire logic sequential_tag_debug,
  input wire logic tag_advance,
  // Block outputs
  output pdc_pkg::pdc_err_t err_report,
  output pdc_pkg::pdc_ctl_t ctl_out,
  output logic [12:0] payload_max_bytes,
  output logic [12:0] orig_req_max_bytes,
  output logic [9:0] power_multiplier_milli,
  output logic orig_relaxed_order,
  output logic orig_no_snoop,
  output logic [7:0] debug_tag
);

  if (ADDR_W != `PDC_ADDR_W) begin : g_bad_addr_w
    $error("pdc_regs needs a 12-bit register address");
  end

  // ****************************************
  // Control register
  // ****************************************
  pdc_pkg::pdc_ctl_t ctl_reg;
  logic [15:0] ctl_wdata;
  logic wr_ctl;
  logic wr_cap;

  assign wr_ctl = reg_wr && (reg_addr == `PDC_OFF_DEVCTL);
  assign wr_cap = reg_wr && (reg_addr == `PDC_OFF_DEVCAP);
  assign ctl_wdata = reg_wdata[15:0] & `PDC_CTL_WMASK;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctl_reg <= '0;
    end else if (wr_ctl) begin
      ctl_reg.corr_err_report_en <= ctl_wdata[`PDC_CTL_CORR_BIT];
      ctl_reg.nonfatal_err_report_en <= ctl_wdata[`PDC_CTL_NONFATAL_BIT];
      ctl_reg.fatal_err_report_en <= ctl_wdata[`PDC_CTL_FATAL_BIT];
      ctl_reg.unsup_req_report_en <= ctl_wdata[`PDC_CTL_UNSUP_BIT];
      ctl_reg.payload_size_sel <= ctl_wdata[`PDC_CTL_PAYLOAD_MSB:`PDC_CTL_PAYLOAD_LSB];
      ctl_reg.ext_tag_en <= ctl_wdata[`PDC_CTL_EXTTAG_BIT];
    end
  end

  assign ctl_out = ctl_reg;

  // ****************************************
  // Capabilities: supported payload and power scale
  // ****************************************
  logic [2:0] payload_size_supported_reg;
  logic [1:0] captured_power_scale_reg;

  // Supported size is loadable by software as a hardware-init value
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      payload_size_supported_reg <= `PDC_CAP_PAYLOAD_RST;
    end else if (wr_cap) begin
      payload_size_supported_reg <= reg_wdata[`PDC_CAP_PAYLOAD_MSB:`PDC_CAP_PAYLOAD_LSB];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      captured_power_scale_reg <= 2'h0;
    end else if (UPSTREAM && power_msg.valid) begin
      captured_power_scale_reg <= power_msg.scale;
    end
  end

  // ****************************************
  // Derived controls
  // ****************************************
  logic [12:0] payload_bytes;

  always_comb begin
    case (ctl_reg.payload_size_sel)
      3'h0: payload_bytes = `PDC_PAYLOAD_128;
      3'h1: payload_bytes = `PDC_PAYLOAD_256;
      3'h2: payload_bytes = `PDC_PAYLOAD_512;
      3'h3: payload_bytes = `PDC_PAYLOAD_1024;
      3'h4: payload_bytes = `PDC_PAYLOAD_2048;
      3'h5: payload_bytes = `PDC_PAYLOAD_4096;
      default: payload_bytes = `PDC_PAYLOAD_128;
    endcase
  end

  logic [9:0] scale_milli;

  always_comb begin
    case (pdc_pkg::pdc_scale_t'(captured_power_scale_reg))
      pdc_pkg::PDC_SCALE_1P0: scale_milli = 10'h3e8;
      pdc_pkg::PDC_SCALE_0P1: scale_milli = 10'h064;
      pdc_pkg::PDC_SCALE_0P01: scale_milli = 10'h00a;
      pdc_pkg::PDC_SCALE_0P001: scale_milli = 10'h001;
      default: scale_milli = 10'h3e8;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      payload_max_bytes <= `PDC_PAYLOAD_128;
      power_multiplier_milli <= 10'h3e8;
    end else begin
      payload_max_bytes <= payload_bytes;
      power_multiplier_milli <= scale_milli;
    end
  end

  // Own requests never carry these attributes or exceed 128 bytes
  assign orig_relaxed_order = 1'b0;
  assign orig_no_snoop = 1'b0;
  assign orig_req_max_bytes = `PDC_ORIG_REQ_MAX;

  // ****************************************
  // Error reporting gates
  // ****************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      err_report <= '0;
    end else begin
      err_report.corr <= err_detect.corr && ctl_reg.corr_err_report_en;
      err_report.nonfatal <= err_detect.nonfatal && ctl_reg.nonfatal_err_report_en;
      err_report.fatal <= err_detect.fatal && ctl_reg.fatal_err_report_en;
      err_report.unsup <= err_detect.unsup && ctl_reg.unsup_req_report_en;
    end
  end

  // ****************************************
  // Debug tag generator
  // ****************************************
  pdc_tag_gen #(
    .TAG_W(8)
  ) u_tag_gen (
    .clock(clock),
    .resetn(resetn),
    .enable(sequential_tag_debug),
    .wide(ctl_reg.ext_tag_en),
    .advance(tag_advance),
    .tag(debug_tag)
  );

  // ****************************************
  // Read path
  // ****************************************
  logic [31:0] ctl_view;
  logic [31:0] cap_view;

  always_comb begin
    ctl_view = 32'h0000_0000;
    ctl_view[`PDC_CTL_CORR_BIT] = ctl_reg.corr_err_report_en;
    ctl_view[`PDC_CTL_NONFATAL_BIT] = ctl_reg.nonfatal_err_report_en;
    ctl_view[`PDC_CTL_FATAL_BIT] = ctl_reg.fatal_err_report_en;
    ctl_view[`PDC_CTL_UNSUP_BIT] = ctl_reg.unsup_req_report_en;
    ctl_view[`PDC_CTL_PAYLOAD_MSB:`PDC_CTL_PAYLOAD_LSB] = ctl_reg.payload_size_sel;
    ctl_view[`PDC_CTL_EXTTAG_BIT] = ctl_reg.ext_tag_en;
    // Bits 4, 9, 10, 11 and 14:12 stay zero
    ctl_view[`PDC_CTL_RELAX_BIT] = 1'b0;
    ctl_view[`PDC_CTL_PHANTOM_BIT] = 1'b0;
    ctl_view[`PDC_CTL_AUXPM_BIT] = 1'b0;
    ctl_view[`PDC_CTL_NOSNOOP_BIT] = 1'b0;
    ctl_view[`PDC_CTL_RDREQ_MSB:`PDC_CTL_RDREQ_LSB] = 3'h0;
  end

  always_comb begin
    cap_view = 32'h0000_0000;
    cap_view[`PDC_CAP_PAYLOAD_MSB:`PDC_CAP_PAYLOAD_LSB] = payload_size_supported_reg;
    cap_view[`PDC_CAP_SCALE_MSB:`PDC_CAP_SCALE_LSB] =
      UPSTREAM ? captured_power_scale_reg : 2'h0;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `PDC_OFF_DEVCTL: reg_rdata <= ctl_view;
        `PDC_OFF_DEVCAP: reg_rdata <= cap_view;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_scale_capture;
    @(posedge clock) disable iff (!resetn)
      (UPSTREAM && power_msg.valid && !wr_cap) ##1 reg_rd && reg_addr == `PDC_OFF_DEVCAP
        |=> reg_rdata[27:26] == $past(power_msg.scale, 2);
  endproperty
  a_scale_capture: assert property (p_scale_capture) else $error("scale not captured");

  property p_scale_map;
    @(posedge clock) disable iff (!resetn)
      captured_power_scale_reg == 2'h1 |=> power_multiplier_milli == 10'h064;
  endproperty
  a_scale_map: assert property (p_scale_map) else $error("scale 1 not 0.1x");

  property p_corr_gate;
    @(posedge clock) disable iff (!resetn)
      err_detect.corr |=> err_report.corr == $past(ctl_reg.corr_err_report_en);
  endproperty
  a_corr_gate: assert property (p_corr_gate) else $error("correctable gate wrong");

  property p_nonfatal_wr;
    @(posedge clock) disable iff (!resetn)
      wr_ctl |=> ctl_reg.nonfatal_err_report_en == $past(reg_wdata[1]);
  endproperty
  a_nonfatal_wr: assert property (p_nonfatal_wr) else $error("non-fatal enable lost");

  property p_fatal_gate;
    @(posedge clock) disable iff (!resetn)
      !ctl_reg.fatal_err_report_en ##1 !ctl_reg.fatal_err_report_en |-> !err_report.fatal;
  endproperty
  a_fatal_gate: assert property (p_fatal_gate) else $error("fatal reported while off");

  property p_unsup_gate;
    @(posedge clock) disable iff (!resetn)
      (err_detect.unsup && ctl_reg.unsup_req_report_en) |=> err_report.unsup;
  endproperty
  a_unsup_gate: assert property (p_unsup_gate) else $error("unsup not reported");

  property p_ro_bits;
    @(posedge clock) disable iff (!resetn)
      reg_rd && reg_addr == `PDC_OFF_DEVCTL |=> reg_rdata[31:9] == 23'h0 && !reg_rdata[4];
  endproperty
  a_ro_bits: assert property (p_ro_bits) else $error("hardwired control bits not zero");

  property p_payload_map;
    @(posedge clock) disable iff (!resetn)
      ctl_reg.payload_size_sel == 3'h5 |=> payload_max_bytes == `PDC_PAYLOAD_4096;
  endproperty
  a_payload_map: assert property (p_payload_map) else $error("code 5 not 4096 bytes");

  property p_payload_rsvd;
    @(posedge clock) disable iff (!resetn)
      ctl_reg.payload_size_sel[2:1] == 2'h3 |=> payload_max_bytes == `PDC_PAYLOAD_128;
  endproperty
  a_payload_rsvd: assert property (p_payload_rsvd) else $error("reserved code not 128");

  property p_cap_rsvd;
    @(posedge clock) disable iff (!resetn)
      reg_rd && reg_addr == `PDC_OFF_DEVCAP
        |=> reg_rdata[31:28] == 4'h0 && reg_rdata[25:3] == 23'h0;
  endproperty
  a_cap_rsvd: assert property (p_cap_rsvd) else $error("reserved cap bits set");

  property p_down_scale;
    @(posedge clock) disable iff (!resetn)
      !UPSTREAM && reg_rd && reg_addr == `PDC_OFF_DEVCAP |=> reg_rdata[27:26] == 2'h0;
  endproperty
  a_down_scale: assert property (p_down_scale) else $error("downstream scale not zero");

  property p_scale_hold;
    @(posedge clock) disable iff (!resetn)
      !power_msg.valid |=> $stable(captured_power_scale_reg);
  endproperty
  a_scale_hold: assert property (p_scale_hold) else $error("scale moved unprompted");

  property p_nf_quiet;
    @(posedge clock) disable iff (!resetn)
      !err_detect.nonfatal |=> !err_report.nonfatal;
  endproperty
  a_nf_quiet: assert property (p_nf_quiet) else $error("non-fatal reported unprompted");

endmodule : pdc_regs

// File: dv/pdc_regs_tb_top.sv
// Self-checking bench for the device control and capabilities register bank.
// Assumes pdc_map.svh and pdc_pkg on the include path; the bench drives every port.
`timescale 1ns/1ps

module pdc_regs_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rdata_up;
  logic [31:0] rdata_dn;
  pdc_pkg::pdc_power_msg_t power_msg = '0;
  pdc_pkg::pdc_err_t err_detect = '0;
  logic sequential_tag_debug = 1'b0;
  logic tag_advance = 1'b0;
  pdc_pkg::pdc_err_t err_report;
  pdc_pkg::pdc_ctl_t ctl_out;
  logic [12:0] payload_max_bytes;
  logic [12:0] orig_req_max_bytes;
  logic [9:0] power_multiplier_milli;
  logic orig_relaxed_order;
  logic orig_no_snoop;
  logic [7:0] debug_tag;
  int fails = 0;
  int n_checks = 0;
  int seed = 70;
  logic rd_seen = 1'b0;
  logic [63:0] exp_q[$];
  logic [12:0] pay_tab [8] = '{13'h0080, 13'h0100, 13'h0200, 13'h0400,
                               13'h0800, 13'h1000, 13'h0080, 13'h0080};
  logic [9:0] mul_tab [4] = '{10'h3e8, 10'h064, 10'h00a, 10'h001};

  always #25 clock = ~clock;

  // ****************************************************************
  // Upstream and downstream instances
  // ****************************************************************
  pdc_regs #(.UPSTREAM(1'b1), .ADDR_W(12)) DUT (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_up), .power_msg(power_msg),
    .err_detect(err_detect), .sequential_tag_debug(sequential_tag_debug),
    .tag_advance(tag_advance), .err_report(err_report), .ctl_out(ctl_out),
    .payload_max_bytes(payload_max_bytes), .orig_req_max_bytes(orig_req_max_bytes),
    .power_multiplier_milli(power_multiplier_milli), .orig_relaxed_order(orig_relaxed_order),
    .orig_no_snoop(orig_no_snoop), .debug_tag(debug_tag)
  );

  pdc_regs #(.UPSTREAM(1'b0), .ADDR_W(12)) dut_dn (
    .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_dn), .power_msg(power_msg),
    .err_detect(err_detect), .sequential_tag_debug(sequential_tag_debug),
    .tag_advance(tag_advance), .err_report(), .ctl_out(), .payload_max_bytes(),
    .orig_req_max_bytes(), .power_multiplier_milli(), .orig_relaxed_order(),
    .orig_no_snoop(), .debug_tag()
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic conclude();
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e_up, input logic [31:0] e_dn);
    @(posedge clock);
    exp_q.push_back({e_dn, e_up});
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      tag_advance <= 1'b0;
    end
    #1;
  endtask : idle

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      tag_advance <= 1'b1;
      @(posedge clock);
      tag_advance <= 1'b0;
    end
    idle(2);
  endtask : pulses

  // ****************************************************************
  // Read data monitor
  // ****************************************************************
  always @(posedge clock) begin
    logic [63:0] e;
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        chk(e[31:0], rdata_up);
        chk(e[63:32], rdata_dn);
      end
    end
    rd_seen <= reg_rd;
  end

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    conclude();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic [3:0] det;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    rd(12'h048, 32'h0, 32'h0);
    rd(12'h044, 32'h4, 32'h4);
    idle(2);
    chk(32'h80, 32'(payload_max_bytes));
    chk(32'h3e8, 32'(power_multiplier_milli));
    // Raise the supported size first so no payload code exceeds it
    wr(12'h044, 32'hffffffff);
    wr(12'h048, 32'hffffffff);
    rd(12'h048, 32'h1ef, 32'h1ef);
    idle(2);
    chk(32'hff, 32'(ctl_out));
    rd(12'h044, 32'h7, 32'h7);
    wr(12'h04c, 32'hffffffff);
    rd(12'h04c, 32'h0, 32'h0);
    rd(12'h040, 32'h0, 32'h0);
    rd(12'h048, 32'h1ef, 32'h1ef);
    idle(2);
    for (int c = 0; c < 8; c++) begin
      wr(12'h048, 32'(c) << 5);
      idle(3);
      chk(32'(pay_tab[c]), 32'(payload_max_bytes));
    end
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      wr(12'h048, r);
      rd(12'h048, r & 32'h1ef, r & 32'h1ef);
      idle(1);
      det = 4'($random(seed));
      @(posedge clock);
      err_detect <= det;
      @(posedge clock);
      #1;
      chk(32'({r[0], r[1], r[2], r[3]} & det), 32'(err_report));
    end
    wr(12'h048, 32'h0);
    wr(12'h044, 32'h4);
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      power_msg <= {1'b1, 8'($random(seed)), 2'(s)};
      rd(12'h044, (32'(s) << 26) | 32'h4, 32'h4);
      power_msg.valid <= 1'b0;
      idle(3);
      chk(32'(mul_tab[s]), 32'(power_multiplier_milli));
    end
    wr(12'h048, 32'h0);
    sequential_tag_debug <= 1'b1;
    idle(1);
    pulses(33);
    chk(32'h1, 32'(debug_tag));
    wr(12'h048, 32'h100);
    sequential_tag_debug <= 1'b0;
    idle(2);
    chk(32'h0, 32'(debug_tag));
    @(posedge clock);
    sequential_tag_debug <= 1'b1;
    pulses(259);
    chk(32'h3, 32'(debug_tag));
    // Leave the wide range above 31, then fall back to the short range
    pulses(30);
    wr(12'h048, 32'h0);
    idle(2);
    chk(32'h1, 32'(debug_tag <= 8'h1f));
    chk(32'h80, 32'(orig_req_max_bytes));
    chk(32'h0, 32'({orig_relaxed_order, orig_no_snoop}));
    // Reset in mid-run must restore every default
    wr(12'h044, 32'h7);
    wr(12'h048, 32'h1ef);
    @(posedge clock);
    resetn <= 1'b0;
    reg_wr <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(12'h048, 32'h0, 32'h0);
    rd(12'h044, 32'h4, 32'h4);
    idle(2);
    chk(32'h3e8, 32'(power_multiplier_milli));
    chk(32'h0, 32'({err_report, debug_tag, ctl_out}));
    idle(3);
    chk(32'h0, 32'(exp_q.size()));
    conclude();
  end
endmodule : pdc_regs_tb_top
